// file: design/codec_pkg.sv
// constants for the 64 kbit/s contradirectional line codec
// assumes a single 100 mhz system clock; all line rates derive from it
package codec_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BIT_RATE_HZ = 64_000;
	localparam int unsigned FREQ_TOL_PPM = 100;
	// whole cycles per bit, plus a fractional remainder spread evenly
	localparam int unsigned BIT_CYC = CLK_HZ / BIT_RATE_HZ;
	localparam int unsigned BIT_FRAC = CLK_HZ % BIT_RATE_HZ;
	localparam int unsigned TIM_DUTY_PCT = 50;
	localparam int unsigned HALF_CYC = BIT_CYC * TIM_DUTY_PCT / 100;
	localparam int CYC_W = 11;
	localparam int ACC_W = 17;
	localparam logic [CYC_W-1:0] CYC_BASE_LAST = CYC_W'(BIT_CYC - 1);
	localparam logic [CYC_W-1:0] CYC_HALF_LAST = CYC_W'(HALF_CYC - 1);
	localparam logic [ACC_W-1:0] ACC_FRAC = ACC_W'(BIT_FRAC);
	localparam logic [ACC_W-1:0] ACC_RATE = ACC_W'(BIT_RATE_HZ);
	localparam int WORD_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam logic [2:0] OCTET_FIRST = 3'h0;
	localparam logic [2:0] OCTET_LAST = 3'h7;
	localparam int DIR_TX = 0;
	localparam int DIR_RX = 1;
	localparam int NUM_DIR = 2;
endpackage

// file: design/contradir_64k_ami_timing_codec.sv
// line-side codec for a 64 kbit/s contradirectional interface
// assumes line drivers turn pos/neg pulse pairs into bipolar levels and
// that the returned data pins are asynchronous to sys_clk_in
//
// Notes on behaviour
// - bit rate 64 kbit/s, fractional divider keeps average exact.
// - each direction has a data line and a composite timing line.
// - data marks are AMI, each lasting the whole bit period.
// - one AMI timing pulse per bit, half a bit period wide.
// - octet phase marked by a timing polarity violation at 8 kHz.
// - alarm input per direction suppresses that direction's violations.
// - returned data sampled at the leading edge of next timing pulse.
// - data transitions only at timing instants, from bit timing.
// - this side sources timing for both directions.
`timescale 1ns/1ps
module contradir_64k_ami_timing_codec
	import codec_pkg::*;
(
	input wire logic sys_clk_in, // 100 mhz system clock
	input wire logic sys_rst_in, // async reset, active high
	input wire logic tx_valid_in, // octet offered for sending
	input wire logic [codec_pkg::WORD_W-1:0] tx_data_in, // octet, msb first
	output logic tx_ready_out, // fifo can take an octet
	input wire logic tx_alarm_in, // suppress violations, send direction
	input wire logic rx_alarm_in, // suppress violations, return direction
	output logic tx_dpos_out, // send data, positive mark
	output logic tx_dneg_out, // send data, negative mark
	output logic tx_tpos_out, // send timing, positive pulse
	output logic tx_tneg_out, // send timing, negative pulse
	output logic rx_tpos_out, // return timing, positive pulse
	output logic rx_tneg_out, // return timing, negative pulse
	input wire logic rx_dpos_in, // returned data, positive mark pin
	input wire logic rx_dneg_in, // returned data, negative mark pin
	output logic rx_valid_out, // one-cycle pulse, octet received
	output logic [codec_pkg::WORD_W-1:0] rx_data_out, // received octet
	output logic rx_code_err_out, // one-cycle pulse, ami error seen
	output logic octet_start_out // one-cycle pulse at each octet start
);
	import codec_pkg::*;

	octet_stream_if #(.W(WORD_W)) fill_if ();
	octet_stream_if #(.W(WORD_W)) drain_if ();

	// the fifo absorbs bursts; it drains one octet per 125 us only
	octet_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clk_in(sys_clk_in),
		.rst_in(sys_rst_in),
		.wr(fill_if.snk),
		.rd(drain_if.src)
	);

	assign fill_if.valid = tx_valid_in;
	assign fill_if.data = tx_data_in;
	assign tx_ready_out = fill_if.ready;

	// returned data pins cross from the far end's timing; two flops each
	logic [1:0] rx_meta_r, rx_sync_r;
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rx_meta_r <= 2'h0;
			rx_sync_r <= 2'h0;
		end else begin
			rx_meta_r <= {rx_dneg_in, rx_dpos_in};
			rx_sync_r <= rx_meta_r;
		end
	end

	// bit timing state
	logic [CYC_W-1:0] cyc_r, cyc_nxt, last_r, last_nxt;
	logic [ACC_W-1:0] acc_r, acc_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic bit_start_w;
	logic [ACC_W-1:0] acc_sum_w;

	// bit period alternates between base and base+1 cycles so the
	// long-run rate is exact rather than off by hundreds of ppm
	always_comb begin
		bit_start_w = (cyc_r == last_r);
		acc_sum_w = acc_r + ACC_FRAC;
		cyc_nxt = cyc_r + 1'b1;
		last_nxt = last_r;
		acc_nxt = acc_r;
		idx_nxt = idx_r;
		if (bit_start_w) begin
			cyc_nxt = '0;
			idx_nxt = idx_r + 1'b1;
			if (acc_sum_w >= ACC_RATE) begin
				acc_nxt = acc_sum_w - ACC_RATE;
				last_nxt = CYC_BASE_LAST + 1'b1;
			end else begin
				acc_nxt = acc_sum_w;
				last_nxt = CYC_BASE_LAST;
			end
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cyc_r <= '0;
			last_r <= CYC_BASE_LAST;
			acc_r <= '0;
			idx_r <= OCTET_LAST;
		end else begin
			cyc_r <= cyc_nxt;
			last_r <= last_nxt;
			acc_r <= acc_nxt;
			idx_r <= idx_nxt;
		end
	end

	// composite timing, one generator per direction
	logic [NUM_DIR-1:0] alarm_w, tpol_r, tpol_nxt;
	logic [NUM_DIR-1:0] tpos_r, tpos_nxt, tneg_r, tneg_nxt;
	logic octet_w;
	assign alarm_w = {rx_alarm_in, tx_alarm_in};
	assign octet_w = bit_start_w && (idx_nxt == OCTET_FIRST);

	genvar d;
	generate
		for (d = 0; d < NUM_DIR; d++) begin : g_tim
			logic viol_w, pol_w;
			always_comb begin
				// alarm inhibits the violation on this direction only
				viol_w = octet_w & ~alarm_w[d];
				pol_w = viol_w ? tpol_r[d] : ~tpol_r[d];
				tpol_nxt[d] = tpol_r[d];
				tpos_nxt[d] = tpos_r[d];
				tneg_nxt[d] = tneg_r[d];
				if (bit_start_w) begin
					tpol_nxt[d] = pol_w;
					tpos_nxt[d] = pol_w;
					tneg_nxt[d] = ~pol_w;
				end else if (cyc_r == CYC_HALF_LAST) begin
					tpos_nxt[d] = 1'b0;
					tneg_nxt[d] = 1'b0;
				end
			end
			always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					tpol_r[d] <= 1'b0;
					tpos_r[d] <= 1'b0;
					tneg_r[d] <= 1'b0;
				end else begin
					tpol_r[d] <= tpol_nxt[d];
					tpos_r[d] <= tpos_nxt[d];
					tneg_r[d] <= tneg_nxt[d];
				end
			end
		end
	endgenerate

	// both timing lines leave this side toward the service side
	assign tx_tpos_out = tpos_r[DIR_TX];
	assign tx_tneg_out = tneg_r[DIR_TX];
	assign rx_tpos_out = tpos_r[DIR_RX];
	assign rx_tneg_out = tneg_r[DIR_RX];

	// send data path
	logic [WORD_W-1:0] tsh_r, tsh_nxt;
	logic mpol_r, mpol_nxt, dpos_r, dpos_nxt, dneg_r, dneg_nxt;
	logic [WORD_W-1:0] word_w;
	logic bitv_w;

	// an empty fifo at an octet start sends an all-zero octet (no marks)
	always_comb begin
		drain_if.ready = octet_w;
		word_w = drain_if.valid ? drain_if.data : '0;
		bitv_w = octet_w ? word_w[WORD_W-1] : tsh_r[WORD_W-1];
		tsh_nxt = tsh_r;
		mpol_nxt = mpol_r;
		dpos_nxt = dpos_r;
		dneg_nxt = dneg_r;
		if (bit_start_w) begin
			tsh_nxt = octet_w ? {word_w[WORD_W-2:0], 1'b0}
				: {tsh_r[WORD_W-2:0], 1'b0};
			dpos_nxt = bitv_w & ~mpol_r;
			dneg_nxt = bitv_w & mpol_r;
			mpol_nxt = bitv_w ? ~mpol_r : mpol_r;
		end
	end

	// marks hold for the whole bit, changing only at bit starts
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			tsh_r <= '0;
			mpol_r <= 1'b1;
			dpos_r <= 1'b0;
			dneg_r <= 1'b0;
		end else begin
			tsh_r <= tsh_nxt;
			mpol_r <= mpol_nxt;
			dpos_r <= dpos_nxt;
			dneg_r <= dneg_nxt;
		end
	end
	assign tx_dpos_out = dpos_r;
	assign tx_dneg_out = dneg_r;

	// return data path
	logic [WORD_W-1:0] rsh_r, rsh_nxt, rdat_r, rdat_nxt;
	logic rval_r, rval_nxt, rerr_r, rerr_nxt, rpol_r, rpol_nxt;
	logic run_r, run_nxt, oct_r, oct_nxt;
	logic mark_w;

	// the service side answers late, so the previous bit is read at the
	// leading edge of the next timing pulse, not at its own
	always_comb begin
		mark_w = rx_sync_r[0] | rx_sync_r[1];
		rsh_nxt = rsh_r;
		rdat_nxt = rdat_r;
		rval_nxt = 1'b0;
		rerr_nxt = 1'b0;
		rpol_nxt = rpol_r;
		run_nxt = run_r;
		oct_nxt = octet_w;
		if (bit_start_w) begin
			run_nxt = 1'b1;
			if (run_r) begin
				rsh_nxt = {rsh_r[WORD_W-2:0], mark_w};
				// both pins active, or a repeated polarity, is a code error
				rerr_nxt = (rx_sync_r[0] & rx_sync_r[1])
					| (rx_sync_r[0] & rpol_r)
					| (rx_sync_r[1] & ~rpol_r);
				if (mark_w) begin
					rpol_nxt = rx_sync_r[0];
				end
				if (idx_r == OCTET_LAST) begin
					rdat_nxt = {rsh_r[WORD_W-2:0], mark_w};
					rval_nxt = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rsh_r <= '0;
			rdat_r <= '0;
			rval_r <= 1'b0;
			rerr_r <= 1'b0;
			rpol_r <= 1'b0;
			run_r <= 1'b0;
			oct_r <= 1'b0;
		end else begin
			rsh_r <= rsh_nxt;
			rdat_r <= rdat_nxt;
			rval_r <= rval_nxt;
			rerr_r <= rerr_nxt;
			rpol_r <= rpol_nxt;
			run_r <= run_nxt;
			oct_r <= oct_nxt;
		end
	end
	assign rx_valid_out = rval_r;
	assign rx_data_out = rdat_r;
	assign rx_code_err_out = rerr_r;
	assign octet_start_out = oct_r;
endmodule

// file: design/octet_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock; depth must be a power of two
`timescale 1ns/1ps
module octet_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk_in, // system clock
	input wire logic rst_in, // async reset, active high
	octet_stream_if.snk wr, // filling side
	octet_stream_if.src rd // draining side
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic full_w, empty_w, push_w, pop_w;

	// full when pointers differ only in the wrap bit
	always_comb begin
		empty_w = (wp_r == rp_r);
		full_w = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
		wr.ready = ~full_w;
		rd.valid = ~empty_w;
		rd.data = mem[rp_r[AW-1:0]];
		push_w = wr.valid & ~full_w;
		pop_w = rd.ready & ~empty_w;
		wp_nxt = push_w ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop_w ? rp_r + 1'b1 : rp_r;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end

	// storage has no reset; only entries between the pointers are read
	always_ff @(posedge clk_in) begin
		if (push_w) begin
			mem[wp_r[AW-1:0]] <= wr.data;
		end
	end
endmodule

// file: design/octet_stream_if.sv
// valid/ready word stream between the codec and its fifo
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface octet_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// file: test/codec_properties.sv
// checker: timing and data line relations of the codec
// assumes it sees only the top ports and is bound from the bench
`timescale 1ns/1ps
module codec_properties (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic tx_tpos_out,
	input wire logic tx_tneg_out,
	input wire logic rx_tpos_out,
	input wire logic rx_tneg_out,
	input wire logic tx_dpos_out,
	input wire logic tx_dneg_out,
	input wire logic tx_alarm_in,
	input wire logic rx_alarm_in,
	input wire logic rx_valid_out,
	input wire logic rx_code_err_out,
	input wire logic octet_start_out
);
	logic t_r, tpol_r, rpol_r, dpol_r, seen_r;
	logic [10:0] hi_r, gap_r;
	logic [2:0] bcnt_r;
	wire t = tx_tpos_out | tx_tneg_out;
	wire lead = t & !t_r;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	// shadow counters restart with the design, so octet bit 0 is the first
	always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			{t_r, tpol_r, rpol_r, seen_r, bcnt_r} <= '0;
			dpol_r <= 1'b1; // design's first mark after reset is negative
			hi_r <= 11'h000;
			gap_r <= 11'h000;
		end else begin
			t_r <= t;
			hi_r <= t ? hi_r + 11'h001 : 11'h000;
			gap_r <= lead ? 11'h000 : gap_r + 11'h001;
			if (lead) begin
				tpol_r <= tx_tpos_out;
				rpol_r <= rx_tpos_out;
				bcnt_r <= bcnt_r + 3'h1;
				seen_r <= 1'b1;
				if (tx_dpos_out | tx_dneg_out)
					dpol_r <= tx_dpos_out;
			end
		end
	end
	a_tim_width: assert property ($fell(t) |-> hi_r == 11'h30d)
		else $error("timing pulse width wrong");
	a_bit_period: assert property (lead && seen_r
		|-> gap_r inside {11'h619, 11'h61a})
		else $error("bit period wrong");
	a_tx_violation: assert property (lead
		|-> (tx_tpos_out == tpol_r)
		== (bcnt_r == 3'h0 && !$past(tx_alarm_in)))
		else $error("send timing violation misplaced");
	a_rx_violation: assert property (lead
		|-> (rx_tpos_out == rpol_r)
		== (bcnt_r == 3'h0 && !$past(rx_alarm_in)))
		else $error("return timing violation misplaced");
	a_same_phase: assert property ((rx_tpos_out | rx_tneg_out) == t)
		else $error("return timing out of phase");
	a_data_instant: assert property (
		$changed({tx_dpos_out, tx_dneg_out}) |-> lead)
		else $error("data moved off a timing instant");
	a_data_ami: assert property (lead && (tx_dpos_out | tx_dneg_out)
		|-> tx_dpos_out == !dpol_r && tx_dneg_out == dpol_r)
		else $error("data mark polarity wrong");
	a_octet_mark: assert property (lead && bcnt_r == 3'h0
		|-> ##[0:1] octet_start_out)
		else $error("octet start missing");
	a_rx_word: assert property (rx_valid_out
		|-> octet_start_out && !$past(rx_valid_out))
		else $error("received word flag misplaced");
	c_alarm: cover property (lead && bcnt_r == 3'h0 && tx_alarm_in);
	c_word: cover property (rx_valid_out);
	c_err: cover property (rx_code_err_out);
endmodule

// file: test/service_model.sv
// service-side terminal: returns one octet per octet of timing
// assumes the return timing pair in and drives the returned data pair
`timescale 1ns/1ps
module service_model (
	input wire logic tpos_in, // timing, positive
	input wire logic tneg_in, // timing, negative
	input wire logic [7:0] word_in, // octet, msb first
	input wire logic bad_in, // repeat mark polarity
	output logic dpos_out, // data, positive mark
	output logic dneg_out // data, negative mark
);
	logic lastt = 1'b0, lastd = 1'b0, bitv;
	logic [2:0] idx = 3'h0;
	initial {dpos_out, dneg_out} = 2'b00;
	// data moves only after the timing edge, late like a real cable
	always @(posedge (tpos_in | tneg_in)) begin
		idx = (tpos_in == lastt) ? 3'h7 : idx - 3'h1;
		lastt = tpos_in;
		bitv = word_in[idx];
		#300;
		if (bitv && !bad_in)
			lastd = !lastd;
		dpos_out = bitv & lastd;
		dneg_out = bitv & !lastd;
	end
endmodule

// file: test/tb.sv
// bench for the line codec: octets out and back, alarm, code errors
// assumes the service model on the return pair and the bound checker
`timescale 1ns/1ps
module tb;
	logic sys_clk_in = 0, sys_rst_in = 1, tx_valid_in = 0, tx_alarm_in = 0;
	logic rx_alarm_in = 0, bad = 0, errs = 0, pol = 1, tpl = 0; // pol: last mark
	logic [7:0] tx_data_in = 8'h00, word = 8'h5a, rx_data_out;
	logic tx_ready_out, tx_dpos_out, tx_dneg_out, tx_tpos_out, tx_tneg_out;
	logic rx_tpos_out, rx_tneg_out, rx_dpos_in, rx_dneg_in, rx_valid_out;
	logic rx_code_err_out, octet_start_out;
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	always #5 sys_clk_in = ~sys_clk_in;
	contradir_64k_ami_timing_codec dut (.sys_clk_in, .sys_rst_in,
		.tx_valid_in, .tx_data_in, .tx_ready_out, .tx_alarm_in,
		.rx_alarm_in, .tx_dpos_out, .tx_dneg_out, .tx_tpos_out,
		.tx_tneg_out, .rx_tpos_out, .rx_tneg_out, .rx_dpos_in,
		.rx_dneg_in, .rx_valid_out, .rx_data_out, .rx_code_err_out,
		.octet_start_out);
	service_model peer (.tpos_in(rx_tpos_out), .tneg_in(rx_tneg_out),
		.word_in(word), .bad_in(bad), .dpos_out(rx_dpos_in),
		.dneg_out(rx_dneg_in));
	// latch any code error pulse, it stands one cycle only
	always @(posedge sys_clk_in)
		if (rx_code_err_out === 1'b1)
			errs <= 1'b1;
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// a hang costs a mismatch; the run needs about 62500 cycles
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 95000) begin
			n_mismatch++;
			close_out();
		end
	end
	task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	// valid stays up between words; caller lowers it
	task automatic send(logic [7:0] d);
		tx_valid_in = 1'b1;
		tx_data_in = d;
		@(posedge sys_clk_in);
		#1;
	endtask
	// one octet: marks and timing polarity per bit, word flags at start
	task automatic octet(logic [7:0] sent, logic alm, logic [7:0] rxw,
		logic dorx);
		logic [7:0] e;
		for (int k = 7; k >= 0; k--) begin
			@(posedge tx_tpos_out or posedge tx_tneg_out);
			#1;
			e = sent[k] ? {6'h0, !pol, pol} : 8'h00;
			chk("send mark", e, {6'h0, tx_dpos_out, tx_dneg_out});
			e = {7'h0, (k == 7 && !alm) ? tpl : !tpl};
			chk("timing pol", e, {7'h0, tx_tpos_out});
			tpl = tx_tpos_out;
			pol = sent[k] ? !pol : pol;
			// the octet flag stands for this one cycle only
			chk("octet start", {7'h0, k == 7}, {7'h0, octet_start_out});
			if (k == 7 && dorx)
				chk("rx word", rxw, rx_data_out);
		end
	endtask
	// two words out, the first returned word back, no false code errors
	task automatic t_send_words();
		send(8'ha5);
		send(8'h3c);
		tx_valid_in = 1'b0;
		octet(8'ha5, 1'b0, 8'h00, 1'b0);
		word = 8'h81;
		octet(8'h3c, 1'b0, 8'h5a, 1'b1);
		chk("code err", 8'h00, {7'h0, errs});
	endtask
	// alarm on both directions while the service side repeats polarity
	task automatic t_alarm_err();
		{tx_alarm_in, rx_alarm_in, word, bad, errs} = 12'hffe;
		octet(8'h00, 1'b1, 8'h81, 1'b1);
		{tx_alarm_in, rx_alarm_in, bad} = 3'h0;
		octet(8'h00, 1'b0, 8'hff, 1'b1);
		chk("code err", 8'h01, {7'h0, errs});
	endtask
	// reset in mid-run, fill the fifo, first word after the reset
	task automatic t_reset_fill();
		sys_rst_in = 1'b1;
		@(posedge sys_clk_in);
		#1 sys_rst_in = 1'b0;
		{tpl, pol} = 2'b01;
		for (int i = 0; i < 32; i++)
			send(8'h10 + 8'(i));
		tx_valid_in = 1'b0;
		chk("fifo full", 8'h00, {7'h0, tx_ready_out});
		octet(8'h10, 1'b0, 8'h00, 1'b0);
	endtask
	initial begin
		repeat (6) @(posedge sys_clk_in);
		#1 sys_rst_in = 1'b0;
		t_send_words();
		t_alarm_err();
		t_reset_fill();
		close_out();
	end
endmodule
bind contradir_64k_ami_timing_codec codec_properties props (.sys_clk_in,
	.sys_rst_in, .tx_tpos_out, .tx_tneg_out, .rx_tpos_out, .rx_tneg_out,
	.tx_dpos_out, .tx_dneg_out, .tx_alarm_in, .rx_alarm_in,
	.rx_valid_out, .rx_code_err_out, .octet_start_out);
